// File: hw/rgbdp_cfg.svh
// Timing and width constants of the 18-bit RGB data-enable panel link
`ifndef RGBDP_CFG_SVH
`define RGBDP_CFG_SVH
`define RGBDP_COLOR_W 6
`define RGBDP_MCLK_KHZ 50000
`define RGBDP_PCLK_MIN_KHZ 29400
`define RGBDP_PCLK_NOM_KHZ 33260
`define RGBDP_PCLK_MAX_KHZ 42480
// Half period of the generated pixel clock in mclk cycles, rounded up, at least one
`define RGBDP_PCLK_HALF_CYC ((`RGBDP_MCLK_KHZ + 2 * `RGBDP_PCLK_NOM_KHZ - 1) / (2 * `RGBDP_PCLK_NOM_KHZ))
`define RGBDP_LINE_MIN_CLK 1000
`define RGBDP_LINE_NOM_CLK 1056
`define RGBDP_LINE_MAX_CLK 1200
`define RGBDP_ACTIVE_CLK 800
`define RGBDP_GAP_MIN_LINES 10
`define RGBDP_GAP_NOM_LINES 45
`define RGBDP_GAP_MAX_LINES 110
`define RGBDP_ACTIVE_LINES 480
`endif

// File: hw/rgbdp_pkg.sv
// Shared types of the RGB data-enable panel link
package rgbdp_pkg;
   typedef logic [5:0] rgbdp_color_t;
   typedef enum logic {RGBDP_CTRL_IDLE, RGBDP_CTRL_RUN} rgbdp_ctrl_state_t;
   typedef enum logic {RGBDP_PNL_SEEK, RGBDP_PNL_LOCKED} rgbdp_pnl_state_t;
endpackage

// File: hw/rgbdp_if.sv
// Pixel link between display controller and panel
`timescale 1ns/1ps
interface rgbdp_if;
   logic pixel_clock_in;
   logic pixel_valid_strobe;
   rgbdp_pkg::rgbdp_color_t red;
   rgbdp_pkg::rgbdp_color_t green;
   rgbdp_pkg::rgbdp_color_t blue;
   modport ctrl (output pixel_clock_in, output pixel_valid_strobe, output red, output green, output blue);
   modport panel (input pixel_clock_in, input pixel_valid_strobe, input red, input green, input blue);
endinterface

// File: hw/rgbdp_panel.sv
// Panel end: samples the pixel link and rebuilds pixels, lines and frames
`timescale 1ns/1ps
`include "rgbdp_cfg.svh"
module rgbdp_panel #(
   parameter int LINE_MIN = `RGBDP_LINE_MIN_CLK,
   parameter int LINE_MAX = `RGBDP_LINE_MAX_CLK,
   parameter int ACTIVE_CLK = `RGBDP_ACTIVE_CLK,
   parameter int ACTIVE_LINES = `RGBDP_ACTIVE_LINES,
   parameter int GAP_MIN = `RGBDP_GAP_MIN_LINES,
   parameter int GAP_MAX = `RGBDP_GAP_MAX_LINES
) (
   input wire logic mclk,
   input wire logic rst_n,
   rgbdp_if.panel lnk,
   output logic pix_valid,
   output rgbdp_pkg::rgbdp_color_t pix_red,
   output rgbdp_pkg::rgbdp_color_t pix_green,
   output rgbdp_pkg::rgbdp_color_t pix_blue,
   output logic [10:0] pix_x,
   output logic [9:0] pix_y,
   output logic frame_start,
   output logic line_len_err,
   output logic width_err,
   output logic frame_err
);
   localparam logic [17:0] SPAN_SAT = 18'h3FFFF;
   localparam logic [17:0] SPAN_LO = 18'((1 + GAP_MIN) * LINE_MIN);
   localparam logic [17:0] SPAN_HI = 18'((1 + GAP_MAX) * LINE_MAX);
   localparam logic [17:0] LMIN = 18'(LINE_MIN);
   localparam logic [17:0] LMAX = 18'(LINE_MAX);
   localparam logic [10:0] AWID = 11'(ACTIVE_CLK);
   localparam logic [9:0] ALINES = 10'(ACTIVE_LINES);

   logic [19:0] sy1, sy2;
   logic clk_prev, de_prev;
   logic [17:0] span, next_span;
   logic [10:0] act, next_act;
   logic [9:0] lines, next_lines;
   rgbdp_pkg::rgbdp_pnl_state_t state, next_state;
   logic next_pix_valid, next_frame_start, next_line_len_err, next_width_err, next_frame_err;
   rgbdp_pkg::rgbdp_color_t next_red, next_green, next_blue;
   logic [10:0] next_x;
   logic [9:0] next_y;
   logic fall, de_now, de_rise, de_fall;

   // Two-flop synchronisers; only the second stage feeds logic
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sy1 <= 20'h00000;
         sy2 <= 20'h00000;
         clk_prev <= 1'b0;
      end else begin
         sy1 <= {lnk.pixel_clock_in, lnk.pixel_valid_strobe, lnk.red, lnk.green, lnk.blue};
         sy2 <= sy1;
         clk_prev <= sy2[19];
      end
   end

   // RL1 falling edge capture
   assign fall = clk_prev & ~sy2[19];
   // RL10 framing from strobe alone
   assign de_now = sy2[18];
   assign de_rise = fall & de_now & ~de_prev;
   assign de_fall = fall & ~de_now & de_prev;

   // Framing, measurement and pixel output
   always_comb begin
      next_state = state;
      next_span = span;
      next_act = act;
      next_lines = lines;
      next_pix_valid = 1'b0;
      next_frame_start = 1'b0;
      next_line_len_err = 1'b0;
      next_width_err = 1'b0;
      next_frame_err = 1'b0;
      next_red = pix_red;
      next_green = pix_green;
      next_blue = pix_blue;
      next_x = pix_x;
      next_y = pix_y;
      if (fall) begin
         next_span = (span == SPAN_SAT) ? span : span + 18'h00001;
         if (de_rise) begin
            next_span = 18'h00001;
            next_act = 11'h000;
            if (span > LMAX) begin
               // Long idle means a blanking gap: a new frame starts
               next_state = rgbdp_pkg::RGBDP_PNL_LOCKED;
               next_frame_start = 1'b1;
               next_lines = 10'h001;
               next_y = 10'h000;
               if (state == rgbdp_pkg::RGBDP_PNL_LOCKED)
                  next_frame_err = (lines != ALINES) || (span < SPAN_LO) || (span > SPAN_HI);
            end else begin
               next_lines = lines + 10'h001;
               next_y = lines;
               if (state == rgbdp_pkg::RGBDP_PNL_LOCKED)
                  next_line_len_err = span < LMIN;
            end
         end
         if (de_now) begin
            // RL7 RL8 RL9 msb-first colour buses
            next_red = sy2[17:12];
            next_green = sy2[11:6];
            next_blue = sy2[5:0];
            next_x = de_rise ? 11'h000 : act;
            next_act = (de_rise ? 11'h000 : act) + 11'h001;
            next_pix_valid = (state == rgbdp_pkg::RGBDP_PNL_LOCKED) || (de_rise && span > LMAX);
         end
         if (de_fall && state == rgbdp_pkg::RGBDP_PNL_LOCKED)
            next_width_err = act != AWID;
      end
   end

   // State registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= rgbdp_pkg::RGBDP_PNL_SEEK;
         de_prev <= 1'b0;
         span <= 18'h00000;
         act <= 11'h000;
         lines <= 10'h000;
         pix_valid <= 1'b0;
         frame_start <= 1'b0;
         line_len_err <= 1'b0;
         width_err <= 1'b0;
         frame_err <= 1'b0;
         pix_red <= 6'h00;
         pix_green <= 6'h00;
         pix_blue <= 6'h00;
         pix_x <= 11'h000;
         pix_y <= 10'h000;
      end else begin
         state <= next_state;
         de_prev <= fall ? de_now : de_prev;
         span <= next_span;
         act <= next_act;
         lines <= next_lines;
         pix_valid <= next_pix_valid;
         frame_start <= next_frame_start;
         line_len_err <= next_line_len_err;
         width_err <= next_width_err;
         frame_err <= next_frame_err;
         pix_red <= next_red;
         pix_green <= next_green;
         pix_blue <= next_blue;
         pix_x <= next_x;
         pix_y <= next_y;
      end
   end
endmodule // rgbdp_panel

// File: hw/rgbdp_ctrl.sv
// Controller end: makes the pixel clock, data-enable framing and colour buses
`timescale 1ns/1ps
`include "rgbdp_cfg.svh"
// Operation
// RL1 - Outputs change on rise, stable at fall
// RL2 - Pixel clock between 29.40 and 42.48 MHz; the default divider of one mclk per half period gives 25 MHz
// RL3 - Line lasts 1000 to 1200 clocks
// RL4 - Strobe high 800 clocks per line
// RL5 - Blank 10 to 110 lines between frames
// RL6 - 480 active lines per frame
// RL7 - Red bus, top bit most significant
// RL8 - Green bus, top bit most significant
// RL9 - Blue bus, top bit most significant
// RL10 - One strobe frames lines and frames
// RL11 - Prefer nominal rate, line and blanking; defaults give nominal line and blanking but a 25 MHz rate
// RL12 - Outputs low until enabled, stop cleanly
module rgbdp_ctrl #(
   parameter int HALF_DIV = `RGBDP_PCLK_HALF_CYC,
   parameter int LINE_CLK = `RGBDP_LINE_NOM_CLK,
   parameter int ACTIVE_CLK = `RGBDP_ACTIVE_CLK,
   parameter int ACTIVE_LINES = `RGBDP_ACTIVE_LINES,
   parameter int GAP_LINES = `RGBDP_GAP_NOM_LINES
) (
   input wire logic mclk,
   input wire logic rst_n,
   rgbdp_if.ctrl lnk,
   input wire logic enable,
   input wire rgbdp_pkg::rgbdp_color_t src_red,
   input wire rgbdp_pkg::rgbdp_color_t src_green,
   input wire rgbdp_pkg::rgbdp_color_t src_blue,
   output logic src_take,
   output logic frame_start,
   output logic line_start,
   output logic busy,
   output logic [15:0] frame_count
);
   // Limits derived from the timing constants
   localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);
   localparam logic [10:0] H_LAST = 11'(LINE_CLK - 1);
   localparam logic [10:0] H_ACT = 11'(ACTIVE_CLK);
   localparam logic [9:0] V_LAST = 10'(ACTIVE_LINES + GAP_LINES - 1);
   localparam logic [9:0] V_ACT = 10'(ACTIVE_LINES);

   rgbdp_pkg::rgbdp_ctrl_state_t state, next_state;
   logic [7:0] div, next_div;
   logic pclk, next_pclk;
   logic [10:0] h, next_h;
   logic [9:0] v, next_v;
   logic de, next_de;
   rgbdp_pkg::rgbdp_color_t red, next_red, green, next_green, blue, next_blue;
   logic next_frame_start, next_line_start;
   logic [15:0] next_frame_count;
   logic rise_evt, active, wrap_line, wrap_frame;

   // RL2 divider from mclk sets the pixel rate
   assign rise_evt = (div == DIV_LAST) && !pclk && (state == rgbdp_pkg::RGBDP_CTRL_RUN);
   // Position at this rise; the counters already name the slot being sent
   assign wrap_line = (h == H_LAST);
   assign wrap_frame = wrap_line && (v == V_LAST);
   // RL4 strobe window per line
   // RL6 only the first lines carry pixels
   assign active = (h < H_ACT) && (v < V_ACT);
   // Pixel is pulled from the source in the cycle it is latched
   assign src_take = rise_evt && active;
   assign busy = (state == rgbdp_pkg::RGBDP_CTRL_RUN);

   // Next-state logic for clock, counters and link outputs
   always_comb begin
      next_state = state;
      next_div = div;
      next_pclk = pclk;
      next_h = h;
      next_v = v;
      next_de = de;
      next_red = red;
      next_green = green;
      next_blue = blue;
      next_frame_start = 1'b0;
      next_line_start = 1'b0;
      next_frame_count = frame_count;
      case (state)
         rgbdp_pkg::RGBDP_CTRL_IDLE: begin
            // RL12 link held low while stopped
            next_div = 8'h00;
            next_pclk = 1'b0;
            next_h = 11'h000;
            next_v = 10'h000;
            next_de = 1'b0;
            next_red = 6'h00;
            next_green = 6'h00;
            next_blue = 6'h00;
            if (enable) begin
               next_state = rgbdp_pkg::RGBDP_CTRL_RUN;
            end
         end
         rgbdp_pkg::RGBDP_CTRL_RUN: begin
            if (div == DIV_LAST) begin
               next_div = 8'h00;
               next_pclk = !pclk;
            end else begin
               next_div = div + 8'h01;
            end
            // RL1 drive new values just after the rising edge
            if (rise_evt) begin
               // RL10 strobe alone marks valid pixels
               next_de = active;
               // RL7 RL8 RL9 buses passed bit for bit
               next_red = active ? src_red : 6'h00;
               next_green = active ? src_green : 6'h00;
               next_blue = active ? src_blue : 6'h00;
               next_line_start = (h == 11'h000) && (v < V_ACT);
               next_frame_start = (h == 11'h000) && (v == 10'h000);
               if (next_frame_start) begin
                  next_frame_count = frame_count + 16'h0001;
               end
               // RL3 fixed line period
               // RL11 nominal figures as defaults
               if (wrap_line) begin
                  next_h = 11'h000;
                  // RL5 blanking lines close each frame
                  next_v = wrap_frame ? 10'h000 : v + 10'h001;
               end else begin
                  next_h = h + 11'h001;
               end
            end
            // RL12 stop only on a frame boundary, link left low
            if (!enable && pclk && (div == DIV_LAST) && (h == 11'h000) && (v == 10'h000) && !de) begin
               next_state = rgbdp_pkg::RGBDP_CTRL_IDLE;
               next_pclk = 1'b0;
               next_div = 8'h00;
            end
         end
         default: begin
            next_state = rgbdp_pkg::RGBDP_CTRL_IDLE;
         end
      endcase
   end

   // Registers only
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= rgbdp_pkg::RGBDP_CTRL_IDLE;
         div <= 8'h00;
         pclk <= 1'b0;
         h <= 11'h000;
         v <= 10'h000;
         de <= 1'b0;
         red <= 6'h00;
         green <= 6'h00;
         blue <= 6'h00;
         frame_start <= 1'b0;
         line_start <= 1'b0;
         frame_count <= 16'h0000;
      end else begin
         state <= next_state;
         div <= next_div;
         pclk <= next_pclk;
         h <= next_h;
         v <= next_v;
         de <= next_de;
         red <= next_red;
         green <= next_green;
         blue <= next_blue;
         frame_start <= next_frame_start;
         line_start <= next_line_start;
         frame_count <= next_frame_count;
      end
   end

   // Link pins straight from flops, no glitches toward the panel
   assign lnk.pixel_clock_in = pclk;
   assign lnk.pixel_valid_strobe = de;
   assign lnk.red = red;
   assign lnk.green = green;
   assign lnk.blue = blue;
endmodule // rgbdp_ctrl

// File: test/rgbdp_chk.sv
// Assertions watching the pixel link between controller and panel
`timescale 1ns/1ps
module rgbdp_chk #(
   parameter int HALF_DIV = 4,
   parameter int LINE_CLK = 40,
   parameter int ACTIVE_CLK = 20,
   parameter int ACTIVE_LINES = 4,
   parameter int GAP_LINES = 2
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pixel_clock_in,
   input wire logic pixel_valid_strobe,
   input wire rgbdp_pkg::rgbdp_color_t red,
   input wire rgbdp_pkg::rgbdp_color_t green,
   input wire rgbdp_pkg::rgbdp_color_t blue
);
   logic [15:0] hi, next_hi, span, next_span, ln, next_ln;
   logic de_q, seen, next_seen, rise;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Strobe high time, rise-to-rise span and line index, in mclk cycles
   always_comb begin
      rise = pixel_valid_strobe && !de_q;
      next_hi = pixel_valid_strobe ? hi + 16'h1 : 16'h0;
      next_span = rise ? 16'h1 : span + 16'h1;
      next_ln = !rise ? ln : (ln == 16'(ACTIVE_LINES - 1)) ? 16'h0 : ln + 16'h1;
      next_seen = seen | rise;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         {hi, span, ln, de_q, seen} <= '0;
      end else begin
         {hi, span, ln, de_q, seen} <= {next_hi, next_span, next_ln, pixel_valid_strobe, next_seen};
      end
   end
   // High phase fixed at four mclk, low phase at least four, so only valid for HALF_DIV of 4
   chk_clk_high_half: assert property ($rose(pixel_clock_in) |=> pixel_clock_in [*3] ##1 !pixel_clock_in)
      else $error("pixel clock high phase wrong");
   chk_clk_low_half: assert property ($fell(pixel_clock_in) |=> !pixel_clock_in [*3])
      else $error("pixel clock low phase too short");
   chk_stable_at_fall: assert property ($fell(pixel_clock_in) |->
      $stable({pixel_valid_strobe, red, green, blue}) ##1 $stable({pixel_valid_strobe, red, green, blue}))
      else $error("link data moved at falling edge");
   chk_strobe_on_clock: assert property ($rose(pixel_valid_strobe) |-> $rose(pixel_clock_in) ##4 $fell(pixel_clock_in))
      else $error("strobe not aligned to pixel clock");
   chk_strobe_width: assert property ($fell(pixel_valid_strobe) |-> hi == 16'(ACTIVE_CLK * 2 * HALF_DIV))
      else $error("strobe high time wrong");
   chk_line_period: assert property (rise && seen && ln != 16'h0 |-> span == 16'(LINE_CLK * 2 * HALF_DIV))
      else $error("line period wrong");
   chk_frame_gap: assert property (rise && seen && ln == 16'h0 |->
      span == 16'((GAP_LINES + 1) * LINE_CLK * 2 * HALF_DIV))
      else $error("frame gap or line count wrong");
   chk_reset_quiet: assert property ($rose(rst_n) |-> {pixel_clock_in, pixel_valid_strobe, red, green, blue} == 20'h0)
      else $error("link not low after reset");
   cover property (rise && seen && ln == 16'h0);
   cover property ($fell(pixel_valid_strobe));
   cover property (!pixel_clock_in [*8]);
endmodule // rgbdp_chk

// File: test/rgb_de_panel_input_bench.sv
// Bench joining controller and panel, plus a faulty link into a second panel
`timescale 1ns/1ps
module rgb_de_panel_input_bench;
   localparam int LN = 40, AC = 20, NL = 4, GP = 2;
   logic mclk = 1'h0, rst_n = 1'h0, enable = 1'h0;
   rgbdp_pkg::rgbdp_color_t sr = 6'h0, sg = 6'h0, sb = 6'h0, pr, pg, pb;
   logic take, c_fs, ls, busy, pv, fs, lerr, werr, ferr, werr2, lerr2, pv2, fs2, ferr2;
   rgbdp_pkg::rgbdp_color_t pr2, pg2, pb2;
   logic [10:0] px2;
   logic [9:0] py2;
   logic [15:0] fc;
   logic [10:0] px;
   logic [9:0] py;
   int n_mismatch = 0, checks = 0, n_src = 0, n_pix = 0, n_wire = 0, n_fs = 0, n_cfs = 0, n_ls = 0;
   int n_err = 0, n_w2 = 0, n_l2 = 0, n_fs2 = 0, n_f2 = 0, hi = 0, span = 0, ln = 0;
   logic de_q = 1'h0;
   rgbdp_if lnk();
   rgbdp_if bad();
   rgbdp_ctrl #(.HALF_DIV(4), .LINE_CLK(LN), .ACTIVE_CLK(AC), .ACTIVE_LINES(NL), .GAP_LINES(GP)) rgbdp_ctrl_i (
      .mclk(mclk), .rst_n(rst_n), .lnk(lnk.ctrl), .enable(enable), .src_red(sr), .src_green(sg), .src_blue(sb),
      .src_take(take), .frame_start(c_fs), .line_start(ls), .busy(busy), .frame_count(fc));
   rgbdp_panel #(.LINE_MIN(30), .LINE_MAX(50), .ACTIVE_CLK(AC), .ACTIVE_LINES(NL), .GAP_MIN(1), .GAP_MAX(3))
      rgbdp_panel_i (.mclk(mclk), .rst_n(rst_n), .lnk(lnk.panel), .pix_valid(pv), .pix_red(pr), .pix_green(pg),
      .pix_blue(pb), .pix_x(px), .pix_y(py), .frame_start(fs), .line_len_err(lerr), .width_err(werr), .frame_err(ferr));
   // Second panel only sees the deliberately broken link
   rgbdp_panel #(.LINE_MIN(30), .LINE_MAX(50), .ACTIVE_CLK(AC), .ACTIVE_LINES(NL), .GAP_MIN(1), .GAP_MAX(3))
      rgbdp_panel_i2 (.mclk(mclk), .rst_n(rst_n), .lnk(bad.panel), .pix_valid(pv2), .pix_red(pr2), .pix_green(pg2),
      .pix_blue(pb2), .pix_x(px2), .pix_y(py2), .frame_start(fs2), .line_len_err(lerr2), .width_err(werr2),
      .frame_err(ferr2));
   rgbdp_chk #(.HALF_DIV(4), .LINE_CLK(LN), .ACTIVE_CLK(AC), .ACTIVE_LINES(NL), .GAP_LINES(GP)) rgbdp_chk_i (
      .mclk(mclk), .rst_n(rst_n), .pixel_clock_in(lnk.pixel_clock_in), .pixel_valid_strobe(lnk.pixel_valid_strobe),
      .red(lnk.red), .green(lnk.green), .blue(lnk.blue));
   initial forever #10 mclk = ~mclk;
   // Colour pattern per pixel index; red counts up so a swapped bit shows
   function automatic logic [17:0] pat(int k);
      return {k[5:0], ~k[5:0], k[5:0] ^ 6'h2A};
   endfunction
   task automatic cmp(string what, logic [19:0] exp, logic [19:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic end_of_test;
      if (n_mismatch == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Source pixels follow the take pulses; sampled mid-cycle to avoid racing the design's edge
   always @(negedge mclk) if (take === 1'h1) n_src <= n_src + 1;
   always @(negedge mclk) {sr, sg, sb} <= pat(n_src);
   // Pulse counters on both sides, read where registered outputs are settled
   always @(negedge mclk) begin
      if ((lerr | werr | ferr) === 1'h1) n_err++;
      if (fs2 === 1'h1) n_fs2++;
      if (ferr2 === 1'h1) n_f2++;
      if (werr2 === 1'h1) n_w2++;
      if (lerr2 === 1'h1) n_l2++;
      if (c_fs === 1'h1) n_cfs++;
      if (ls === 1'h1) n_ls++;
      if (fs === 1'h1) n_fs++;
      if (pv === 1'h1) begin
         // Panel locks only after the first gap, so it starts at the second frame
         cmp("panel pixel", pat(n_pix + NL * AC), {pr, pg, pb});
         cmp("panel x", n_pix % AC, px);
         cmp("panel y", (n_pix / AC) % NL, py);
         n_pix++;
      end
   end
   // Wire monitor at the capturing edge: data, width and rise-to-rise span
   always @(negedge lnk.pixel_clock_in) begin
      if (lnk.pixel_valid_strobe === 1'h1) begin
         cmp("wire pixel", pat(n_wire), {lnk.red, lnk.green, lnk.blue});
         n_wire++;
      end
      if (lnk.pixel_valid_strobe && !de_q) begin
         if (ln > 0) cmp("line span", (ln % NL == 0) ? (GP + 1) * LN : LN, span);
         ln++;
         span = 0;
      end
      if (!lnk.pixel_valid_strobe && de_q) cmp("line width", AC, hi);
      hi = lnk.pixel_valid_strobe ? hi + 1 : 0;
      span++;
      de_q = lnk.pixel_valid_strobe;
   end
   // Faulty far end: 160 ns link clock, toggling through the blanking lines as well as inside frames
   task automatic bad_line(int h, int n);
      for (int i = 0; i < n; i++) begin
         #80 bad.pixel_clock_in = 1'h1;
         bad.pixel_valid_strobe = i < h;
         #80 bad.pixel_clock_in = 1'h0;
      end
   endtask
   initial begin
      {bad.pixel_clock_in, bad.pixel_valid_strobe, bad.red, bad.green, bad.blue} = 20'h0;
      #1007;
      bad_line(0, 80);
      bad_line(AC, LN);
      bad_line(AC, LN);
      bad_line(AC - 3, LN);
      bad_line(AC, 25);
      bad_line(AC, LN);
      bad_line(0, 80);
   end
   initial begin
      #400000;
      n_mismatch++;
      end_of_test;
   end
   // Three frames, then stop at the frame boundary
   initial begin
      repeat (16) @(negedge mclk);
      rst_n = 1'h1;
      @(negedge mclk);
      enable = 1'h1;
      for (int i = 0; i < 8000 && n_cfs < 3; i++) @(negedge mclk);
      enable = 1'h0;
      for (int i = 0; i < 4000 && busy !== 1'h0; i++) @(negedge mclk);
      repeat (8) @(negedge mclk);
      cmp("frame count", 3, fc);
      cmp("line starts", 3 * NL, n_ls);
      cmp("source takes", 3 * NL * AC, n_src);
      cmp("wire pixels", 3 * NL * AC, n_wire);
      cmp("panel pixels", 2 * NL * AC, n_pix);
      cmp("panel frames", 2, n_fs);
      cmp("ctrl frames", 3, n_cfs);
      cmp("bad link frames", 1, n_fs2);
      cmp("bad link frame errors", 0, n_f2);
      cmp("link idle", 0, {lnk.pixel_clock_in, lnk.pixel_valid_strobe, lnk.red, lnk.green, lnk.blue});
      cmp("panel errors", 0, n_err);
      cmp("width errors", 1, n_w2);
      cmp("length errors", 1, n_l2);
      end_of_test;
   end
endmodule // rgb_de_panel_input_bench
